// ==== rtl/qdac_pkg.sv ====
// Package for the quad DAC serial command unit: field layout, commands, structs
package qdac_pkg;

    // Word layout, MSB first
    localparam int WORD_BITS     = 16;
    localparam int CODE_BITS     = 10;
    localparam int CHANNELS      = 4;
    localparam int ADDR_HI_POS   = 15;
    localparam int ADDR_LO_POS   = 14;
    localparam int CMD_HI_POS    = 13;
    localparam int CMD_LO_POS    = 12;
    localparam int CODE_MSB_POS  = 11;
    localparam int CODE_LSB_POS  = 2;
    localparam int SUB_HI_POS    = 1;
    localparam int SUB_LO_POS    = 0;

    // Reset values and full-word bit count
    localparam logic [CODE_BITS-1:0] CODE_RESET = 10'h000;
    localparam logic                 MODE_RESET = 1'b0;
    localparam logic [4:0]           COUNT_FULL = 5'h10;

    // Settling time after wake, figure as printed, and cycle count at 100 MHz
    localparam int WAKE_SETTLE_US = 20;
    localparam int CLK_MHZ        = 100;
    localparam int WAKE_CYCLES    = WAKE_SETTLE_US * CLK_MHZ;

    // Four-bit address/control codes and two-bit control field codes
    localparam logic [3:0] CMD_NOP       = 4'h0;
    localparam logic [3:0] CMD_UPO_LOW   = 4'h2;
    localparam logic [3:0] CMD_RECALL    = 4'h4;
    localparam logic [3:0] CMD_UPO_HIGH  = 4'h6;
    localparam logic [3:0] CMD_LOAD_ALL  = 4'h8;
    localparam logic [3:0] CMD_MODE0     = 4'ha;
    localparam logic [3:0] CMD_SHUTDOWN  = 4'hc;
    localparam logic [3:0] CMD_MODE1     = 4'he;
    localparam logic [1:0] CTL_LOAD_IN   = 2'h1;
    localparam logic [1:0] CTL_LOAD_UPD  = 2'h3;

    // Decoded word
    typedef struct packed {
        logic [1:0]           channel;
        logic [1:0]           control;
        logic [CODE_BITS-1:0] code;
        logic [1:0]           sub;
    } qdac_word_t;

    // Converter register contents of all channels
    typedef struct packed {
        logic [CODE_BITS-1:0] ch_d;
        logic [CODE_BITS-1:0] ch_c;
        logic [CODE_BITS-1:0] ch_b;
        logic [CODE_BITS-1:0] ch_a;
    } qdac_codes_t;

endpackage : qdac_pkg

// ==== rtl/qdac_sync.sv ====
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module qdac_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,    // System clock
    input  wire logic             arst_n, // Async reset, low active
    input  wire logic [WIDTH-1:0] rst_val,// Unused; reset always loads zero
    input  wire logic [WIDTH-1:0] d,      // Asynchronous inputs
    output logic      [WIDTH-1:0] q       // Synchronised outputs
);
    logic [WIDTH-1:0] meta_q;

    // Second flop is the only reader of the first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

    logic unused_rst_val;
    assign unused_rst_val = ^rst_val;

endmodule : qdac_sync

// ==== rtl/qdac_cmd_unit.sv ====
// Serial command front end of a quad 10-bit DAC, sampled on the system clock
// Summary of operation
// - One 16-bit shift register, in and out
// - Each channel: input then converter register
// - Word MSB first: addr, control, code, sub
// - Control 01 loads addressed input register only
// - Control 11 loads input, updates all converters
// - Code 0100 recalls converters, leaves shutdown
// - Code 1000 loads code into all converters
// - Code 1100 shuts down when lockout high
// - Lockout low blocks shutdown, keeps running
// - Codes 0010/0110 drive user output low/high
// - Code 0000 changes nothing
// - Code 1110 picks rising-edge out, updates converters
// - Clear zeroes registers and all outputs except outputs_settled
// - Interface shifts only while select low
// - Shutdown keeps interface and input registers
// - Recall or broadcast load ends shutdown
// - Shift register drives serial data output
// - Code 1010 picks falling-edge out, updates converters
// - Sample on rising clock, act on select rise
// - Output lags input 15.5 or 16 clocks
// - Power-up clears codes, output mode 0
`timescale 1ns/1ps
module qdac_cmd_unit (
    input  wire logic                clk,                // System clock, 100 MHz
    input  wire logic                arst_n,             // Power-on reset, low active
    input  wire logic                clear_all_n,        // Clear pin, low active
    input  wire logic                chip_select_n,      // Chip select pin, low active
    input  wire logic                serial_clk,         // Serial clock pin
    input  wire logic                serial_din,         // Serial data in pin
    input  wire logic                shutdown_lockout_n, // Shutdown lockout pin, low active
    output logic                     serial_dout,        // Serial data out
    output logic                     user_logic_out,     // User logic output
    output logic                     shutdown,           // Converters powered down
    output logic                     dout_mode,          // 0: falling edge, 1: rising edge
    output logic                     outputs_settled,    // Settle time elapsed since wake
    output qdac_pkg::qdac_codes_t    dac_codes           // Converter register contents
);

    // Synchronised pins
    logic [3:0] pins_s;
    logic       cs_n_s;
    logic       sclk_s;
    logic       din_s;
    logic       lock_n_s;

    qdac_sync #(.WIDTH(4)) u_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .rst_val (4'h0),
        .d       ({chip_select_n, serial_clk, serial_din, shutdown_lockout_n}),
        .q       (pins_s)
    );

    assign cs_n_s   = pins_s[3];
    assign sclk_s   = pins_s[2];
    assign din_s    = pins_s[1];
    assign lock_n_s = pins_s[0];

    // Clear pin, also synchronised (second stage only read)
    logic clr_meta_q;
    logic clr_n_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clr_meta_q <= 1'b0;
            clr_n_q    <= 1'b0;
        end else begin
            clr_meta_q <= clear_all_n;
            clr_n_q    <= clr_meta_q;
        end
    end

    // Edge history
    logic sclk_prev_q;
    logic cs_prev_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_prev_q   <= cs_n_s;
        end
    end

    // Edge decode; serial activity only with select low
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic clearing;
    assign clearing  = !clr_n_q;
    assign sclk_rise = sclk_s && !sclk_prev_q && !cs_n_s;
    assign sclk_fall = !sclk_s && sclk_prev_q && !cs_n_s;
    assign cs_rise   = cs_n_s && !cs_prev_q;

    // Shift register and bit count
    logic [qdac_pkg::WORD_BITS-1:0] shift_q, shift_d;
    logic [4:0]                     count_q, count_d;

    assign shift_d = sclk_rise ? {shift_q[qdac_pkg::WORD_BITS-2:0], din_s} : shift_q;
    assign count_d = cs_rise ? 5'h00 :
                     (sclk_rise && count_q != qdac_pkg::COUNT_FULL) ? count_q + 5'h01 :
                     count_q;

    // Shift register process
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= 16'h0000;
            count_q <= 5'h00;
        end else if (clearing) begin
            shift_q <= 16'h0000;
            count_q <= 5'h00;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
        end
    end

    // Word fields
    qdac_pkg::qdac_word_t word;
    logic [3:0]           cmd;
    logic                 act;
    assign word = qdac_pkg::qdac_word_t'(shift_q);
    assign cmd  = {word.channel, word.control};
    assign act  = cs_rise && (count_q == qdac_pkg::COUNT_FULL);

    // Command decode
    logic load_in;
    logic upd_all;
    logic load_all;
    logic go_down;
    logic wake;
    assign load_in  = act && (word.control == qdac_pkg::CTL_LOAD_IN ||
                              word.control == qdac_pkg::CTL_LOAD_UPD);
    assign upd_all  = act && (word.control == qdac_pkg::CTL_LOAD_UPD ||
                              cmd == qdac_pkg::CMD_RECALL ||
                              cmd == qdac_pkg::CMD_MODE0 ||
                              cmd == qdac_pkg::CMD_MODE1);
    assign load_all = act && cmd == qdac_pkg::CMD_LOAD_ALL;
    assign go_down  = act && cmd == qdac_pkg::CMD_SHUTDOWN && lock_n_s;
    assign wake     = act && (cmd == qdac_pkg::CMD_RECALL ||
                              cmd == qdac_pkg::CMD_LOAD_ALL);

    // Input and converter register arrays
    logic [qdac_pkg::CODE_BITS-1:0] in_reg_q  [qdac_pkg::CHANNELS];
    logic [qdac_pkg::CODE_BITS-1:0] in_reg_d  [qdac_pkg::CHANNELS];
    logic [qdac_pkg::CODE_BITS-1:0] dac_reg_q [qdac_pkg::CHANNELS];
    logic [qdac_pkg::CODE_BITS-1:0] dac_reg_d [qdac_pkg::CHANNELS];

    // Next values per channel; converter update sees the freshly loaded input
    for (genvar i = 0; i < qdac_pkg::CHANNELS; i++) begin : g_ch
        assign in_reg_d[i]  = (load_in && word.channel == 2'(i)) ? word.code :
                              in_reg_q[i];
        assign dac_reg_d[i] = load_all ? word.code :
                              upd_all  ? in_reg_d[i] :
                              dac_reg_q[i];
    end

    // Channel register process; input registers survive shutdown
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < qdac_pkg::CHANNELS; i++) begin
                in_reg_q[i]  <= qdac_pkg::CODE_RESET;
                dac_reg_q[i] <= qdac_pkg::CODE_RESET;
            end
        end else if (clearing) begin
            for (int i = 0; i < qdac_pkg::CHANNELS; i++) begin
                in_reg_q[i]  <= qdac_pkg::CODE_RESET;
                dac_reg_q[i] <= qdac_pkg::CODE_RESET;
            end
        end else begin
            for (int i = 0; i < qdac_pkg::CHANNELS; i++) begin
                in_reg_q[i]  <= in_reg_d[i];
                dac_reg_q[i] <= dac_reg_d[i];
            end
        end
    end

    // Mode, user output and shutdown state
    logic mode_d;
    logic upo_d;
    logic sd_d;
    logic lock_prev_q;
    assign mode_d = (act && cmd == qdac_pkg::CMD_MODE1) ? 1'b1 :
                    (act && cmd == qdac_pkg::CMD_MODE0) ? 1'b0 :
                    dout_mode;
    assign upo_d  = (act && cmd == qdac_pkg::CMD_UPO_HIGH) ? 1'b1 :
                    (act && cmd == qdac_pkg::CMD_UPO_LOW)  ? 1'b0 :
                    user_logic_out;
    assign sd_d   = go_down ? 1'b1 :
                    (wake || !lock_n_s) ? 1'b0 :
                    shutdown;

    // State flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dout_mode      <= qdac_pkg::MODE_RESET;
            user_logic_out <= 1'b0;
            shutdown       <= 1'b0;
            lock_prev_q    <= 1'b1;
        end else if (clearing) begin
            dout_mode      <= qdac_pkg::MODE_RESET;
            user_logic_out <= 1'b0;
            shutdown       <= 1'b0;
            lock_prev_q    <= lock_n_s;
        end else begin
            dout_mode      <= mode_d;
            user_logic_out <= upo_d;
            shutdown       <= sd_d;
            lock_prev_q    <= lock_n_s;
        end
    end

    // Serial output: mode 0 changes on falling edge, mode 1 on rising edge
    logic dout_d;
    logic out_edge;
    assign out_edge = dout_mode ? sclk_rise : sclk_fall;
    assign dout_d   = out_edge ? shift_q[qdac_pkg::WORD_BITS-1] : serial_dout;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_dout <= 1'b0;
        end else if (clearing) begin
            serial_dout <= 1'b0;
        end else begin
            serial_dout <= dout_d;
        end
    end

    // Converter outputs, forced to zero in clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dac_codes <= '0;
        end else if (clearing) begin
            dac_codes <= '0;
        end else begin
            dac_codes <= {dac_reg_d[3], dac_reg_d[2], dac_reg_d[1], dac_reg_d[0]};
        end
    end

    // Settle counter after power-up or wake
    logic [11:0] settle_q;
    logic        settled_d;
    assign settled_d = !shutdown && (settle_q == 12'(qdac_pkg::WAKE_CYCLES - 1));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_q        <= 12'h000;
            outputs_settled <= 1'b0;
        end else if (shutdown) begin
            settle_q        <= 12'h000;
            outputs_settled <= 1'b0;
        end else begin
            if (settle_q != 12'(qdac_pkg::WAKE_CYCLES - 1)) begin
                settle_q <= settle_q + 12'h001;
            end
            outputs_settled <= settled_d;
        end
    end

    logic unused_sub;
    assign unused_sub = ^word.sub ^ lock_prev_q;

    // Assertions
    a_short_word_ignored: assert property (@(posedge clk) disable iff (!arst_n)
        (cs_rise && count_q != qdac_pkg::COUNT_FULL && !clearing) |=>
            (dac_codes == $past(dac_codes) && dout_mode == $past(dout_mode)))
        else $error("short word changed state");

    a_input_only_load: assert property (@(posedge clk) disable iff (!arst_n)
        (act && word.control == qdac_pkg::CTL_LOAD_IN && !clearing) |=>
            (in_reg_q[$past(word.channel)] == $past(word.code) &&
             dac_codes == $past(dac_codes)))
        else $error("input load touched converters");

    a_load_update_all: assert property (@(posedge clk) disable iff (!arst_n)
        (act && word.control == qdac_pkg::CTL_LOAD_UPD && !clearing) |=>
            (dac_reg_q[$past(word.channel)] == $past(word.code)))
        else $error("load and update failed");

    a_broadcast_load: assert property (@(posedge clk) disable iff (!arst_n)
        (load_all && !clearing) |=>
            (dac_codes.ch_a == $past(word.code) && dac_codes.ch_d == $past(word.code)
             && !shutdown))
        else $error("broadcast load failed");

    a_lockout_blocks: assert property (@(posedge clk) disable iff (!arst_n)
        (!lock_n_s) |=> !shutdown)
        else $error("shutdown while locked out");

    a_shutdown_entry: assert property (@(posedge clk) disable iff (!arst_n)
        (act && cmd == qdac_pkg::CMD_SHUTDOWN && lock_n_s && !clearing) |=> shutdown)
        else $error("shutdown not entered");

    a_user_out_set: assert property (@(posedge clk) disable iff (!arst_n)
        (act && cmd == qdac_pkg::CMD_UPO_HIGH && !clearing) |=> ##1 user_logic_out[*2])
        else $error("user output not high");

    a_mode_select: assert property (@(posedge clk) disable iff (!arst_n)
        (act && cmd == qdac_pkg::CMD_MODE1 && !clearing) |=> dout_mode)
        else $error("mode 1 not taken");

    a_clear_zeroes: assert property (@(posedge clk) disable iff (!arst_n)
        clearing |=> (dac_codes == '0 && !user_logic_out && !serial_dout))
        else $error("clear left outputs set");

    a_nop_keeps: assert property (@(posedge clk) disable iff (!arst_n)
        (act && cmd == qdac_pkg::CMD_NOP && !clearing) |=>
            ($stable(dac_codes) && $stable(user_logic_out) && $stable(shutdown)))
        else $error("nop changed state");

    // Named steps: a full word acted on with a given code, and a load while down
    sequence s_cmd_seen(logic [3:0] code_v);
        act && cmd == code_v && !clearing;
    endsequence

    sequence s_down_load;
        shutdown && load_in && lock_n_s && !clearing;
    endsequence

    a_recall_wakes: assert property (@(posedge clk) disable iff (!arst_n)
        s_cmd_seen(qdac_pkg::CMD_RECALL) |=>
            (!shutdown && dac_codes.ch_a == in_reg_q[0] && dac_codes.ch_d == in_reg_q[3]))
        else $error("recall did not copy inputs");

    a_mode0_select: assert property (@(posedge clk) disable iff (!arst_n)
        s_cmd_seen(qdac_pkg::CMD_MODE0) |=> !dout_mode)
        else $error("mode 0 not taken");

    a_user_out_clr: assert property (@(posedge clk) disable iff (!arst_n)
        s_cmd_seen(qdac_pkg::CMD_UPO_LOW) |=> !user_logic_out)
        else $error("user output not low");

    a_down_keeps_input: assert property (@(posedge clk) disable iff (!arst_n)
        s_down_load |=> (shutdown && in_reg_q[$past(word.channel)] == $past(word.code)))
        else $error("load while down lost");

    a_idle_select: assert property (@(posedge clk) disable iff (!arst_n)
        (cs_n_s && !clearing) |=> (shift_q == $past(shift_q)))
        else $error("shift moved while deselected");

    a_dout_source: assert property (@(posedge clk) disable iff (!arst_n)
        (out_edge && !clearing) |=> (serial_dout == $past(shift_q[qdac_pkg::WORD_BITS-1])))
        else $error("serial out not from shift msb");

endmodule : qdac_cmd_unit

// ==== dv/qdac_host_model.sv ====
// Serial host model that frames 16-bit command words for the command unit
`timescale 1ns/1ps
module qdac_host_model (
    input  wire logic clk,           // System clock, used only for timing
    input  wire logic serial_dout,   // Echo from the unit
    output logic      chip_select_n, // Select, low active
    output logic      serial_clk,    // Serial clock, still low between frames
    output logic      serial_din     // Serial data
);
    localparam int HALF_CLKS = 8;   // 80 ns halves give a 160 ns serial period
    logic [15:0]   echo_q;          // Echo bits, sampled half a period after the edge that moves them
    logic          rise_mode = 1'b0; // Unit shifts out on the rise: sample before the fall

    // Idle pins at time zero
    initial begin
        chip_select_n = 1'b1;
        serial_clk    = 1'b0;
        serial_din    = 1'b0;
        echo_q        = 16'h0000;
    end

    // Wait n clocks, then land just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Follow the unit's echo edge mode
    task automatic set_rise_mode(input logic m);
        rise_mode = m;
    endtask : set_rise_mode

    // One byte MSB first; data changes only while the serial clock is low
    task automatic shift_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            serial_din = b[i];
            tick(HALF_CLKS);
            if (!rise_mode) begin
                echo_q = {echo_q[14:0], serial_dout};
            end
            serial_clk = 1'b1;
            tick(HALF_CLKS);
            if (rise_mode) begin
                echo_q = {echo_q[14:0], serial_dout};
            end
            serial_clk = 1'b0;
        end
    endtask : shift_byte

    // Select goes low a full period before the first rise
    task automatic open_frame();
        chip_select_n = 1'b0;
        tick(HALF_CLKS);
    endtask : open_frame

    // Select rises; the released data line flips so no stale level lingers
    task automatic close_frame();
        tick(HALF_CLKS);
        chip_select_n = 1'b1;
        serial_din    = ~serial_din;
        tick(12);
    endtask : close_frame

    // Whole word with select held low, optionally as two bytes with a pause
    task automatic send_word(input logic [15:0] wd, input logic split);
        open_frame();
        shift_byte(wd[15:8]);
        if (split) begin
            tick(40);
        end
        shift_byte(wd[7:0]);
        close_frame();
    endtask : send_word
endmodule : qdac_host_model

// ==== dv/quad_dac_serial_command_unit_tb.sv ====
// Self-checking bench for the quad DAC serial command unit
`timescale 1ns/1ps
module quad_dac_serial_command_unit_tb;
    logic                  clk;                // System clock
    logic                  arst_n;             // Reset, low active
    logic                  clear_all_n;        // Clear pin
    logic                  shutdown_lockout_n; // Lockout pin
    logic                  chip_select_n;      // Select from host
    logic                  serial_clk;         // Serial clock from host
    logic                  serial_din;         // Data from host
    logic                  serial_dout;        // Echo to host
    logic                  user_logic_out;     // User output
    logic                  shutdown;           // Shutdown state
    logic                  dout_mode;          // Echo edge mode
    logic                  outputs_settled;    // Settle status
    qdac_pkg::qdac_codes_t dac_codes;          // Converter codes
    qdac_pkg::qdac_codes_t dac_exp;            // Expected converter codes
    int                    num_errors;         // Mismatch count
    int                    num_checks;         // Comparison count
    int                    cycles;             // Watchdog count
    logic [9:0]            cur [4];            // Expected input register codes

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    qdac_cmd_unit DUT (.clk(clk), .arst_n(arst_n), .clear_all_n(clear_all_n),
        .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_din(serial_din),
        .shutdown_lockout_n(shutdown_lockout_n), .serial_dout(serial_dout),
        .user_logic_out(user_logic_out), .shutdown(shutdown), .dout_mode(dout_mode),
        .outputs_settled(outputs_settled), .dac_codes(dac_codes));

    qdac_host_model host (.clk(clk), .serial_dout(serial_dout),
        .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_din(serial_din));

    // Word builder with both sub-bits zero
    function automatic logic [15:0] w(input logic [3:0] cmd, input logic [9:0] code);
        return {cmd, code, 2'b00};
    endfunction : w

    // Expected converter codes when they mirror the input registers
    function automatic qdac_pkg::qdac_codes_t cv();
        return {cur[3], cur[2], cur[1], cur[0]};
    endfunction : cv

    task automatic print_verdict();
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk_bit(input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk_word

    task automatic chk_codes(input qdac_pkg::qdac_codes_t exp, input qdac_pkg::qdac_codes_t got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk_codes

    // Load all input registers one by one; converters must not move
    task automatic load_inputs(input logic [9:0] a, b, c, d);
        logic [9:0] v [4];
        v = '{a, b, c, d};
        for (int i = 0; i < 4; i++) begin
            host.send_word(w({i[1:0], qdac_pkg::CTL_LOAD_IN}, v[i]), 1'b0);
            chk_codes(dac_exp, dac_codes);
        end
        cur = v;
    endtask : load_inputs

    task automatic t_reset();
        chk_codes('0, dac_codes);
        chk_bit(1'b0, dout_mode);
        chk_bit(1'b0, user_logic_out);
        chk_bit(1'b0, shutdown);
    endtask : t_reset

    // Input stage, recall, and load-with-update sent as two bytes
    task automatic t_buffers();
        load_inputs(10'h3ff, 10'h001, 10'h200, 10'h155);
        host.send_word(w(qdac_pkg::CMD_RECALL, 10'h3c3), 1'b0);
        chk_codes(cv(), dac_codes);
        cur[1] = 10'h0aa;
        host.send_word(w({2'h1, qdac_pkg::CTL_LOAD_UPD}, 10'h0aa), 1'b1);
        chk_codes(cv(), dac_codes);
    endtask : t_buffers

    // Shutdown entry, loads while down, recall, settle time, lockout
    task automatic t_shutdown();
        host.send_word(w(qdac_pkg::CMD_SHUTDOWN, 10'h000), 1'b0);
        chk_bit(1'b1, shutdown);
        cur[0] = 10'h123;
        host.send_word(w({2'h0, qdac_pkg::CTL_LOAD_IN}, 10'h123), 1'b0);
        chk_bit(1'b1, shutdown);
        host.send_word(w(qdac_pkg::CMD_RECALL, 10'h000), 1'b0);
        chk_bit(1'b0, shutdown);
        chk_codes(cv(), dac_codes);
        chk_bit(1'b0, outputs_settled);
        host.tick(2000);
        chk_bit(1'b1, outputs_settled);
        shutdown_lockout_n = 1'b0;
        host.send_word(w(qdac_pkg::CMD_SHUTDOWN, 10'h000), 1'b0);
        chk_bit(1'b0, shutdown);
        shutdown_lockout_n = 1'b1;
    endtask : t_shutdown

    // Short frame, no-op, then broadcast load that also wakes the part
    task automatic t_load_all();
        host.open_frame();
        host.shift_byte(8'h8f);
        host.close_frame();
        chk_codes(cv(), dac_codes);
        host.send_word(w(qdac_pkg::CMD_NOP, 10'h3ff), 1'b0);
        chk_codes(cv(), dac_codes);
        host.send_word(w(qdac_pkg::CMD_SHUTDOWN, 10'h000), 1'b0);
        host.send_word(w(qdac_pkg::CMD_LOAD_ALL, 10'h2cd), 1'b0);
        chk_bit(1'b0, shutdown);
        chk_codes({4{10'h2cd}}, dac_codes);
        dac_exp = {4{10'h2cd}};
    endtask : t_load_all

    // Both echo modes; the echo of a word appears while the next one shifts
    task automatic t_modes();
        load_inputs(10'h011, 10'h122, 10'h233, 10'h344);
        host.send_word(w(qdac_pkg::CMD_MODE1, 10'h000), 1'b0);
        chk_bit(1'b1, dout_mode);
        chk_codes(cv(), dac_codes);
        dac_exp = cv();
        host.set_rise_mode(1'b1);
        host.send_word(w(qdac_pkg::CMD_NOP, 10'h2b6), 1'b0);
        host.send_word(w(qdac_pkg::CMD_NOP, 10'h000), 1'b0);
        chk_word(w(qdac_pkg::CMD_NOP, 10'h2b6), host.echo_q);
        load_inputs(10'h3fe, 10'h0f0, 10'h00f, 10'h2a5);
        host.send_word(w(qdac_pkg::CMD_MODE0, 10'h000), 1'b0);
        chk_bit(1'b0, dout_mode);
        chk_codes(cv(), dac_codes);
        host.set_rise_mode(1'b0);
        host.send_word(w(qdac_pkg::CMD_NOP, 10'h159), 1'b0);
        host.send_word(w(qdac_pkg::CMD_NOP, 10'h000), 1'b0);
        chk_word(w(qdac_pkg::CMD_NOP, 10'h159), host.echo_q);
    endtask : t_modes

    // User output both ways, then the clear pin
    task automatic t_upo_clear();
        host.send_word(w(qdac_pkg::CMD_UPO_HIGH, 10'h000), 1'b0);
        chk_bit(1'b1, user_logic_out);
        host.send_word(w(qdac_pkg::CMD_UPO_LOW, 10'h3ff), 1'b0);
        chk_bit(1'b0, user_logic_out);
        host.send_word(w(qdac_pkg::CMD_UPO_HIGH, 10'h000), 1'b0);
        shutdown_lockout_n = 1'b0;
        host.send_word(w(qdac_pkg::CMD_SHUTDOWN, 10'h3ff), 1'b0);
        chk_bit(1'b1, serial_dout);
        shutdown_lockout_n = 1'b1;
        clear_all_n = 1'b0;
        host.tick(8);
        chk_codes('0, dac_codes);
        chk_bit(1'b0, user_logic_out);
        chk_bit(1'b0, serial_dout);
        clear_all_n = 1'b1;
        host.tick(8);
    endtask : t_upo_clear

    // Main sequence
    initial begin
        num_errors = 0;
        num_checks = 0;
        cycles = 0;
        dac_exp = '0;
        arst_n = 1'b0;
        clear_all_n = 1'b1;
        shutdown_lockout_n = 1'b1;
        repeat (16) @(posedge clk);
        #1 arst_n = 1'b1;
        host.tick(4);
        t_reset();
        t_buffers();
        t_shutdown();
        t_load_all();
        t_modes();
        t_upo_clear();
        print_verdict();
    end

    // Watchdog against a hung handshake
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end
endmodule : quad_dac_serial_command_unit_tb
